/* File: core_instruction_decode_timing.sv */
// Instruction decode, cycle timing and read-modify-write datapath
`timescale 1ns/1ps
module core_instruction_decode_timing import core_pkg::*; (
	input  wire logic              sys_clk,      // oscillator clock, 25 MHz
	input  wire logic              rstn,         // async reset, low
	input  wire logic [INSN_W-1:0] prog_data,    // program memory word
	input  wire logic [DATA_W-1:0] file_rdata,   // register file read data
	output logic      [PC_W-1:0]   prog_addr_q,  // program memory address
	output file_req_t              file_req_q,   // register file request
	output logic      [DATA_W-1:0] w_q,          // accumulator
	output status_t                status_q,     // status flags
	output logic                   cycle_start_q // first clock of a cycle
);
	typedef enum logic [2:0] {
		ST_EXEC  = 3'b001,
		ST_FLUSH = 3'b010,
		ST_STALL = 3'b100
	} state_t;

	state_t            state_q;
	logic [1:0]        q_q;
	logic [INSN_W-1:0] ir_q;
	logic [INSN_W-1:0] fetch_q;
	logic [PC_W-1:0]   pc_q;
	logic [DATA_W-1:0] opnd_q;
	logic [PTR_W-1:0]  ptr_q [2];
	decode_t           dec;
	logic [PC_W-1:0]   stack_top;

	// Nibble-split adder giving carry and digit carry
	function automatic logic [9:0] add_c(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [4:0] lo;
		logic [4:0] hi;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		return {hi[4], lo[4], hi[3:0], lo[3:0]};
	endfunction

	insn_field_decode u_dec (
		.ir  (ir_q),
		.dec (dec)
	);

	wire is_byte = ~dec.is_lit & ~dec.is_bit;
	wire is_bitg = dec.is_bit;
	wire is_litg = dec.is_lit & ~dec.is_jump_call;
	wire is_ctl  = is_litg & (dec.op == LOP_CTL);
	wire is_ild  = is_ctl & (dec.csub[5:POS_CS] == CS_IND_LOAD);
	wire is_ist  = is_ctl & (dec.csub[5:POS_CS] == CS_IND_STORE);
	wire is_ret  = (is_ctl & (dec.csub == CS_RETURN || dec.csub == CS_RET_INT))
		| (is_litg & dec.op == LOP_RET_LIT);
	wire is_cacc = is_ctl & (dec.csub == CS_CALL_ACC);
	wire is_bacc = is_ctl & (dec.csub == CS_BR_ACC);
	wire is_bra  = is_litg & (dec.op == LOP_REL_BR);
	wire is_call = dec.is_jump_call & dec.k11[10];
	wire is_ptrl = is_litg & (dec.op[3:2] == LOP_PTR_LO[3:2]);

	// pointer pair from n or from file address
	wire        ind_file = (is_byte | is_bitg) & (dec.f == ADDR_IND0 || dec.f == ADDR_IND1);
	wire        ind_n    = (is_ild | is_ist) ? dec.n : dec.f[0];
	wire        is_ind   = ind_file | is_ild | is_ist;
	wire [15:0] ptr_cur  = ptr_q[ind_n];
	wire [15:0] ptr_step = dec.pointer_update_mode[0] ? ptr_cur - 16'h0001
		: ptr_cur + 16'h0001;
	wire        pre_mod  = (is_ild | is_ist) & ~dec.pointer_update_mode[1];
	wire [15:0] ptr_eff  = pre_mod ? ptr_step : ptr_cur;
	wire        ind_prog = is_ind & ptr_eff[PTR_PROG];
	wire        uses_file = is_byte | is_bitg | is_ild | is_ist;
	wire [15:0] eff_addr = is_ind ? ptr_eff : {9'h000, dec.f};

	wire [9:0] add_fw = add_c(opnd_q, w_q, 1'b0);
	wire [9:0] sub_fw = add_c(opnd_q, ~w_q, 1'b1);
	wire [9:0] inc_f  = add_c(opnd_q, 8'h01, 1'b0);
	wire [9:0] dec_f  = add_c(opnd_q, 8'hFF, 1'b0);
	wire [9:0] add_kw = add_c(dec.k8, w_q, 1'b0);
	wire [9:0] sub_kw = add_c(dec.k8, ~w_q, 1'b1);
	wire [7:0] bmask  = 8'h01 << dec.b;

	logic [7:0] alu_res;
	status_t    st_n;
	logic       to_w;
	logic       to_f;
	logic       skip;
	logic       z_upd;

	always_comb begin
		alu_res = opnd_q;
		st_n    = status_q;
		to_w    = 1'b0;
		to_f    = 1'b0;
		skip    = 1'b0;
		z_upd   = 1'b0;
		if (is_byte) begin
			to_f  = dec.d;
			to_w  = ~dec.d;
			z_upd = 1'b1;
			case (dec.op)
				BOP_MOVWF: begin
					alu_res = w_q;
					to_f    = 1'b1;
					to_w    = 1'b0;
					z_upd   = 1'b0;
				end
				BOP_CLR:   alu_res = 8'h00;
				BOP_SUB:   {st_n.c, st_n.digit_carry_flag, alu_res} = sub_fw;
				BOP_DEC:   alu_res = dec_f[7:0];
				BOP_IOR:   alu_res = opnd_q | w_q;
				BOP_AND:   alu_res = opnd_q & w_q;
				BOP_XOR:   alu_res = opnd_q ^ w_q;
				BOP_ADD:   {st_n.c, st_n.digit_carry_flag, alu_res} = add_fw;
				BOP_MOV:   alu_res = opnd_q;
				BOP_COM:   alu_res = ~opnd_q;
				BOP_INC:   alu_res = inc_f[7:0];
				BOP_DECSZ: begin
					alu_res = dec_f[7:0];
					skip    = (dec_f[7:0] == 8'h00);
					z_upd   = 1'b0;
				end
				BOP_SWAP: begin
					alu_res = {opnd_q[3:0], opnd_q[7:4]};
					z_upd   = 1'b0;
				end
				BOP_RR: begin
					{alu_res, st_n.c} = {status_q.c, opnd_q};
					z_upd             = 1'b0;
				end
				BOP_RL: begin
					{st_n.c, alu_res} = {opnd_q, status_q.c};
					z_upd             = 1'b0;
				end
				default: begin
					alu_res = inc_f[7:0];
					skip    = (inc_f[7:0] == 8'h00);
					z_upd   = 1'b0;
				end
			endcase
		end else if (is_bitg) begin
			case (dec.bop)
				BIT_CLR: begin
					alu_res = opnd_q & ~bmask;
					to_f    = 1'b1;
				end
				BIT_SET: begin
					alu_res = opnd_q | bmask;
					to_f    = 1'b1;
				end
				BIT_SKIP_CLR: skip = ~|(opnd_q & bmask);
				default:      skip = |(opnd_q & bmask);
			endcase
		end else if (is_ild) begin
			to_w  = 1'b1;
			z_upd = 1'b1;
		end else if (is_ist) begin
			alu_res = w_q;
			to_f    = 1'b1;
		end else if (is_ctl) begin
			if (dec.csub == CS_CLRWDT) begin
				st_n.timeout_flag   = 1'b1;
				st_n.powerdown_flag = 1'b1;
			end else if (dec.csub == CS_SLEEP) begin
				st_n.timeout_flag   = 1'b1;
				st_n.powerdown_flag = 1'b0;
			end
		end else if (is_litg) begin
			to_w    = ~is_bra & ~is_ptrl;
			alu_res = dec.k8;
			z_upd   = (dec.op != LOP_MOVLW) & (dec.op != LOP_RET_LIT);
			case (dec.op)
				LOP_ADDLW: {st_n.c, st_n.digit_carry_flag, alu_res} = add_kw;
				LOP_ANDLW: alu_res = dec.k8 & w_q;
				LOP_IORLW: alu_res = dec.k8 | w_q;
				LOP_XORLW: alu_res = dec.k8 ^ w_q;
				LOP_SUBLW: {st_n.c, st_n.digit_carry_flag, alu_res} = sub_kw;
				default:   alu_res = dec.k8;
			endcase
		end
		if (z_upd) begin
			st_n.z = (alu_res == 8'h00);
		end
	end

	// flow changes cost a flush cycle
	wire flow = dec.is_jump_call | is_ret | is_cacc | is_bacc | is_bra | skip;
	wire [PC_W-1:0] next_pc =
		dec.is_jump_call ? {pc_q[14:10], dec.k11[9:0]} :
		is_ret  ? stack_top :
		is_cacc ? {pc_q[14:8], w_q} :
		is_bacc ? pc_q + {7'h00, w_q} :
		is_bra  ? pc_q + {{7{dec.k8[7]}}, dec.k8} :
		pc_q + 15'h0001;

	wire at_q0    = (q_q == Q_DECODE);
	wire at_q1    = (q_q == Q_READ);
	wire at_q2    = (q_q == Q_MODIFY);
	wire at_q3    = (q_q == Q_WRITE);
	// first pass of a program-memory access only stalls
	wire stall    = (state_q == ST_EXEC) & ind_prog;
	wire commit   = at_q3 & ~stall;
	wire do_push  = commit & (is_call | is_cacc);
	wire do_pop   = commit & is_ret;
	wire ptr_wr   = commit & (is_ild | is_ist);
	wire ptr_ld   = commit & is_ptrl;

	ret_stack #(
		.AW    (PC_W),
		.DEPTH (STACK_DEPTH)
	) u_stack (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.push    (do_push),
		.pop     (do_pop),
		.wdata   (pc_q),
		.top_q   (stack_top)
	);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			q_q           <= Q_DECODE;
			cycle_start_q <= 1'b0;
		end else begin
			q_q           <= q_q + 2'h1;
			cycle_start_q <= at_q3;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_EXEC;
		end else if (at_q3) begin
			state_q <= stall ? ST_STALL : (flow ? ST_FLUSH : ST_EXEC);
		end
	end

	// flushed prefetch replaced by a no-op
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ir_q <= NOP_WORD;
		end else if (at_q0 && state_q != ST_STALL) begin
			ir_q <= (state_q == ST_FLUSH) ? NOP_WORD : fetch_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fetch_q     <= NOP_WORD;
			pc_q        <= PC_RESET;
			prog_addr_q <= PC_RESET;
		end else if (at_q1 && stall) begin
			prog_addr_q <= ptr_eff[PC_W-1:0];
		end else if (at_q2 && state_q == ST_STALL) begin
			prog_addr_q <= pc_q;
		end else if (commit) begin
			fetch_q     <= prog_data;
			pc_q        <= next_pc;
			prog_addr_q <= next_pc;
		end
	end

	// read issued even for write-only operands
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			file_req_q <= '0;
			opnd_q     <= 8'h00;
		end else begin
			if (at_q1) begin
				file_req_q.rd   <= uses_file & ~ind_prog;
				file_req_q.addr <= eff_addr;
			end else if (at_q2) begin
				file_req_q.rd <= 1'b0;
				opnd_q        <= (state_q == ST_STALL) ? prog_data[7:0] : file_rdata;
			end
			// Program memory is read-only through a pointer
			file_req_q.wr <= commit & to_f & ~ind_prog;
			if (commit) begin
				file_req_q.wdata <= alu_res;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			w_q      <= W_RESET;
			status_q <= STATUS_RESET;
		end else if (commit) begin
			status_q <= st_n;
			if (to_w) begin
				w_q <= alu_res;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ptr_q[0] <= PTR_RESET;
			ptr_q[1] <= PTR_RESET;
		end else if (ptr_wr) begin
			ptr_q[ind_n] <= ptr_step;
		end else if (ptr_ld) begin
			if (dec.op[0]) begin
				ptr_q[dec.op[1]][15:8] <= dec.k8;
			end else begin
				ptr_q[dec.op[1]][7:0] <= dec.k8;
			end
		end
	end
endmodule // core_instruction_decode_timing

/* File: core_pkg.sv */
// Shared constants and types for the instruction decode and timing core
package core_pkg;

	localparam int INSN_W      = 14;
	localparam int PC_W        = 15;
	localparam int DATA_W      = 8;
	localparam int FADDR_W     = 7;
	localparam int PTR_W       = 16;
	localparam int STACK_DEPTH = 16;

	// Oscillator clocks per instruction cycle and the phase numbers
	localparam int         OSC_PER_CYCLE = 4;
	localparam logic [1:0] Q_DECODE      = 2'h0;
	localparam logic [1:0] Q_READ        = 2'h1;
	localparam logic [1:0] Q_MODIFY      = 2'h2;
	localparam logic [1:0] Q_WRITE       = 2'h3;

	// Field positions inside the instruction word, and the program-memory bit of a pointer
	localparam int POS_LIT  = 13;
	localparam int POS_SUB  = 12;
	localparam int POS_OP   = 8;
	localparam int POS_BOP  = 10;
	localparam int POS_BIT  = 7;
	localparam int POS_D    = 7;
	localparam int POS_N    = 2;
	localparam int POS_MM   = 0;
	localparam int POS_CS   = 3;
	localparam int PTR_PROG = 15;

	// Byte-oriented operations
	localparam logic [3:0] BOP_MOVWF = 4'h0;
	localparam logic [3:0] BOP_CLR   = 4'h1;
	localparam logic [3:0] BOP_SUB   = 4'h2;
	localparam logic [3:0] BOP_DEC   = 4'h3;
	localparam logic [3:0] BOP_IOR   = 4'h4;
	localparam logic [3:0] BOP_AND   = 4'h5;
	localparam logic [3:0] BOP_XOR   = 4'h6;
	localparam logic [3:0] BOP_ADD   = 4'h7;
	localparam logic [3:0] BOP_MOV   = 4'h8;
	localparam logic [3:0] BOP_COM   = 4'h9;
	localparam logic [3:0] BOP_INC   = 4'hA;
	localparam logic [3:0] BOP_DECSZ = 4'hB;
	localparam logic [3:0] BOP_SWAP  = 4'hC;
	localparam logic [3:0] BOP_RR    = 4'hD;
	localparam logic [3:0] BOP_RL    = 4'hE;
	localparam logic [3:0] BOP_INCSZ = 4'hF;

	// Bit-oriented operations
	localparam logic [1:0] BIT_CLR      = 2'h0;
	localparam logic [1:0] BIT_SET      = 2'h1;
	localparam logic [1:0] BIT_SKIP_CLR = 2'h2;
	localparam logic [1:0] BIT_SKIP_SET = 2'h3;

	// Literal and control operations
	localparam logic [3:0] LOP_MOVLW   = 4'h0;
	localparam logic [3:0] LOP_ADDLW   = 4'h1;
	localparam logic [3:0] LOP_ANDLW   = 4'h2;
	localparam logic [3:0] LOP_IORLW   = 4'h3;
	localparam logic [3:0] LOP_XORLW   = 4'h4;
	localparam logic [3:0] LOP_SUBLW   = 4'h5;
	localparam logic [3:0] LOP_RET_LIT = 4'h6;
	localparam logic [3:0] LOP_REL_BR  = 4'h7;
	localparam logic [3:0] LOP_PTR_LO  = 4'h8;
	localparam logic [3:0] LOP_PTR_HI  = 4'h9;
	localparam logic [3:0] LOP_CTL     = 4'hC;

	// Control sub-codes in the low six bits
	localparam logic [5:0] CS_NOP       = 6'h00;
	localparam logic [5:0] CS_RETURN    = 6'h01;
	localparam logic [5:0] CS_RET_INT   = 6'h02;
	localparam logic [5:0] CS_CALL_ACC  = 6'h03;
	localparam logic [5:0] CS_BR_ACC    = 6'h04;
	localparam logic [5:0] CS_CLRWDT    = 6'h05;
	localparam logic [5:0] CS_SLEEP     = 6'h06;
	localparam logic [2:0] CS_IND_LOAD  = 3'h2;
	localparam logic [2:0] CS_IND_STORE = 3'h3;

	// Pointer update modes: bit 1 post, bit 0 decrement
	localparam logic [1:0] MM_PRE_INC  = 2'h0;
	localparam logic [1:0] MM_PRE_DEC  = 2'h1;
	localparam logic [1:0] MM_POST_INC = 2'h2;
	localparam logic [1:0] MM_POST_DEC = 2'h3;

	localparam logic [6:0]  ADDR_IND0 = 7'h00;
	localparam logic [6:0]  ADDR_IND1 = 7'h01;
	localparam logic [13:0] NOP_WORD  = 14'h2C00;

	localparam logic [14:0] PC_RESET  = 15'h0000;
	localparam logic [7:0]  W_RESET   = 8'h00;
	localparam logic [15:0] PTR_RESET = 16'h0000;

	typedef struct packed {
		logic timeout_flag;
		logic powerdown_flag;
		logic z;
		logic digit_carry_flag;
		logic c;
	} status_t;

	localparam status_t STATUS_RESET = 5'h18;

	typedef struct packed {
		logic        is_lit;
		logic        is_bit;
		logic        is_jump_call;
		logic [3:0]  op;
		logic [1:0]  bop;
		logic [5:0]  csub;
		logic [6:0]  f;
		logic [2:0]  b;
		logic        d;
		logic [7:0]  k8;
		logic [10:0] k11;
		logic        n;
		logic [1:0]  pointer_update_mode;
	} decode_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} file_req_t;

endpackage

/* File: insn_field_decode.sv */
// Splits a 14-bit instruction word into its operand fields
`timescale 1ns/1ps
module insn_field_decode import core_pkg::*; (
	input  wire logic [INSN_W-1:0] ir,  // instruction word
	output decode_t                dec  // operand fields
);
	assign dec.is_lit              = ir[POS_LIT];
	assign dec.is_bit              = ~ir[POS_LIT] & ir[POS_SUB];
	assign dec.is_jump_call        = ir[POS_LIT] & ir[POS_SUB];
	assign dec.op                  = ir[POS_OP +: 4];
	assign dec.bop                 = ir[POS_BOP +: 2];
	assign dec.csub                = ir[5:0];
	assign dec.f                   = ir[FADDR_W-1:0];
	assign dec.b                   = ir[POS_BIT +: 3];
	assign dec.d                   = ir[POS_D];
	assign dec.k8                  = ir[7:0];
	assign dec.k11                 = ir[10:0];
	assign dec.n                   = ir[POS_N];
	assign dec.pointer_update_mode = ir[POS_MM +: 2];
endmodule // insn_field_decode

/* File: ret_stack.sv */
// Return address stack with registered top-of-stack read
`timescale 1ns/1ps
module ret_stack #(
	parameter int AW    = 15,
	parameter int DEPTH = 16
) (
	input  wire logic          sys_clk, // clock
	input  wire logic          rstn,    // async reset, low
	input  wire logic          push,    // store wdata
	input  wire logic          pop,     // drop top entry
	input  wire logic [AW-1:0] wdata,   // address pushed
	output logic      [AW-1:0] top_q    // current top entry
);
	localparam int SW = $clog2(DEPTH);
	logic [AW-1:0] mem [DEPTH];
	logic [SW-1:0] sp_q;
	wire  [SW-1:0] sp_top = sp_q - SW'(1);

	// Overflow wraps silently, as a small hardware stack does
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sp_q <= '0;
		end else if (push) begin
			sp_q <= sp_q + SW'(1);
		end else if (pop) begin
			sp_q <= sp_top;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[sp_q] <= wdata;
		end
		top_q <= mem[sp_top];
	end
endmodule // ret_stack

/* File: core_instruction_decode_timing_props.sv */
// Concurrent checks on the decode and timing core ports
`timescale 1ns/1ps
module core_instruction_decode_timing_props import core_pkg::*; (
	input wire logic              sys_clk,       // clock
	input wire logic              rstn,          // async reset, low
	input wire logic [PC_W-1:0]   prog_addr_q,   // program address
	input wire file_req_t         file_req_q,    // file request
	input wire logic [DATA_W-1:0] w_q,           // accumulator
	input wire status_t           status_q,      // status flags
	input wire logic              cycle_start_q  // cycle start pulse
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_three_quiet;
		!cycle_start_q [*3];
	endsequence

	sequence s_read_pulse;
		file_req_q.rd ##1 !file_req_q.rd;
	endsequence

	a_cycle_four_clocks: assert property (
		cycle_start_q |=> s_three_quiet ##1 cycle_start_q)
		else $error("cycle start not every four clocks");
	a_read_one_clock: assert property (file_req_q.rd |-> s_read_pulse)
		else $error("read request longer than one clock");
	a_read_phase_two: assert property (file_req_q.rd |-> $past(cycle_start_q, 2))
		else $error("read request outside its phase");
	a_write_after_read: assert property (
		file_req_q.wr |-> $past(file_req_q.rd, 2) && file_req_q.addr == $past(file_req_q.addr, 2))
		else $error("write without the operand read before it");
	a_write_one_clock: assert property (file_req_q.wr |=> !file_req_q.wr)
		else $error("write request longer than one clock");
	a_write_at_start: assert property (file_req_q.wr |-> cycle_start_q)
		else $error("write not at the start of a cycle");
	a_acc_commit_edge: assert property ($changed(w_q) |-> cycle_start_q)
		else $error("accumulator changed mid cycle");
	a_flags_commit_edge: assert property ($changed(status_q) |-> cycle_start_q)
		else $error("flags changed mid cycle");
	a_reset_state: assert property (
		$rose(rstn) |-> status_q == STATUS_RESET && w_q == W_RESET && prog_addr_q == PC_RESET)
		else $error("state after reset wrong");

	c_write_seen: cover property (file_req_q.wr);
endmodule // core_instruction_decode_timing_props

bind core_instruction_decode_timing core_instruction_decode_timing_props u_props (
	.sys_clk       (sys_clk),
	.rstn          (rstn),
	.prog_addr_q   (prog_addr_q),
	.file_req_q    (file_req_q),
	.w_q           (w_q),
	.status_q      (status_q),
	.cycle_start_q (cycle_start_q)
);

/* File: code_and_file_model.sv */
// Program memory and data register file facing the core
`timescale 1ns/1ps
module code_and_file_model import core_pkg::*; (
	input  wire logic              sys_clk,    // clock
	input  wire logic [PC_W-1:0]   prog_addr,  // fetch address
	input  wire file_req_t         file_req,   // file request
	output logic      [INSN_W-1:0] prog_data,  // fetched word
	output logic      [DATA_W-1:0] file_rdata  // file read data
);
	logic [INSN_W-1:0] code [0:255];
	logic [DATA_W-1:0] regs [0:127];
	logic [DATA_W-1:0] last_q = 8'hA5;
	wire               code_hit = (prog_addr[14:8] == 7'h00);

	// Outside the loaded image only no-operations come back
	assign prog_data  = code_hit ? code[prog_addr[7:0]] : NOP_WORD;
	// Released data line never repeats a stale byte
	assign file_rdata = file_req.rd ? regs[file_req.addr[6:0]] : ~last_q;

	always @(posedge sys_clk) begin
		if (file_req.rd)
			last_q <= file_rdata;
		if (file_req.wr)
			regs[file_req.addr[6:0]] <= file_req.wdata;
	end
endmodule // code_and_file_model

/* File: core_instruction_decode_timing_tb.sv */
// Self-checking bench for the decode and timing core
`timescale 1ns/1ps
module core_instruction_decode_timing_tb import core_pkg::*;;
	typedef struct {
		logic [15:0] addr;
		logic [7:0]  data;
		int          gap;
	} note_t;

	logic              sys_clk = 1'b0;
	logic              rstn = 1'b0;
	logic [PC_W-1:0]   prog_addr_q;
	file_req_t         file_req_q;
	logic [DATA_W-1:0] w_q;
	status_t           status_q;
	logic              cycle_start_q;
	logic [INSN_W-1:0] prog_data;
	logic [DATA_W-1:0] file_rdata;
	int                bad_count = 0;
	int                checks_done = 0;
	int                cyc = 0;
	int                last_cyc = 0;
	integer            seed = 32'h9E7A;
	note_t             notes[$];
	logic [7:0]        k, r21, r22, v40, v41;
	logic [2:0]        bsel;
	logic [8:0]        sum;
	logic              dc;

	always #20 sys_clk = ~sys_clk;

	core_instruction_decode_timing dut (
		.sys_clk              (sys_clk),
		.rstn                 (rstn),
		.prog_data            (prog_data),
		.file_rdata           (file_rdata),
		.prog_addr_q          (prog_addr_q),
		.file_req_q           (file_req_q),
		.w_q                  (w_q),
		.status_q             (status_q),
		.cycle_start_q        (cycle_start_q)
	);

	code_and_file_model mem (
		.sys_clk    (sys_clk),
		.prog_addr  (prog_addr_q),
		.file_req   (file_req_q),
		.prog_data  (prog_data),
		.file_rdata (file_rdata)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch at %0t: %s seen %h want %h", $time, what, seen, want);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic note(input logic [6:0] f, input logic [7:0] d, input int g);
		notes.push_back('{{9'h000, f}, d, g});
	endtask

	// Oldest note is matched against each write as it appears
	// Sampled mid-clock, where registered outputs are settled
	always @(negedge sys_clk) begin : watch
		note_t n;
		if (cycle_start_q === 1'b1)
			cyc++;
		if (file_req_q.wr === 1'b1) begin
			if (notes.size() == 0) begin
				check(file_req_q.addr, 16'hFFFF, "unexpected write");
			end else begin
				n = notes.pop_front();
				check(file_req_q.addr, n.addr, "write address");
				check({8'h00, file_req_q.wdata}, {8'h00, n.data}, "write data");
				if (n.gap > 0)
					check(16'(cyc - last_cyc), 16'(n.gap), "cycles between writes");
				last_cyc = cyc;
			end
		end
	end

	initial begin : main
		int i;
		{k, r21, r22, v40} = $random(seed);
		{v41, bsel} = 11'($random(seed));
		for (i = 0; i < 256; i++)
			mem.code[i] = NOP_WORD;
		for (i = 0; i < 128; i++)
			mem.regs[i] = 8'h00;
		mem.regs[7'h21] = r21;
		mem.regs[7'h22] = r22;
		mem.code[0]  = {6'h20, k};
		mem.code[1]  = 14'h00A0;
		mem.code[2]  = 14'h07A1;
		mem.code[3]  = 14'h3410;
		mem.code[4]  = {4'h5, bsel, 7'h22};
		mem.code[5]  = {4'h7, bsel, 7'h22};
		mem.code[6]  = 14'h00A3;
		mem.code[7]  = 14'h00A4;
		mem.code[8]  = 14'h2840;
		mem.code[9]  = 14'h2980;
		mem.code[10] = 14'h2C12;
		mem.code[11] = 14'h00A6;
		// Don't-care bits set high on the second indirect load
		mem.code[12] = 14'h2CD2;
		mem.code[13] = 14'h00A7;
		mem.code[14] = 14'h300E;
		mem.code[16] = 14'h00A5;
		mem.code[17] = 14'h2C01;
		mem.code[64] = {6'h00, v40};
		mem.code[65] = {6'h00, v41};
		sum = {1'b0, r21} + {1'b0, k};
		dc = ({1'b0, r21[3:0]} + {1'b0, k[3:0]}) > 5'h0F;
		note(7'h20, k, 0);
		note(7'h21, r21 + k, 1);
		note(7'h25, k, 3);
		note(7'h22, r22 | (8'h01 << bsel), 3);
		note(7'h24, k, 3);
		note(7'h26, v40, 5);
		note(7'h27, v41, 3);
		@(negedge sys_clk);
		check(prog_addr_q, PC_RESET, "address in reset");
		check(w_q, W_RESET, "accumulator in reset");
		check(status_q, STATUS_RESET, "flags in reset");
		check({file_req_q.rd, file_req_q.wr}, 2'b00, "requests in reset");
		repeat (4) @(negedge sys_clk);
		rstn = 1'b1;
		for (i = 0; i < 400 && notes.size() > 0; i++)
			@(negedge sys_clk);
		if (notes.size() != 0) begin
			bad_count++;
			$display("mismatch at %0t: expected writes never came", $time);
		end else begin
			repeat (8) @(negedge sys_clk);
			check(w_q, v41, "accumulator after loads");
			check(status_q, {2'b11, v41 == 8'h00, dc, sum[8]}, "final flags");
		end
		stop_test();
	end
endmodule // core_instruction_decode_timing_tb
